// >>> rtl/cip_ctrl_pkg.sv
// ----------------------------------------------------------------
// Shared constants for the component input control block
// ----------------------------------------------------------------
package cip_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register subaddresses
  // ----------------------------------------------------------------
  localparam logic [7:0] SUB_CHROMA_SAT = 8'h90;
  localparam logic [7:0] SUB_HUE_ROT = 8'h91;
  localparam logic [7:0] SUB_LEVEL_GAIN = 8'h92;
  localparam logic [7:0] SUB_MIX_A = 8'h94;
  localparam logic [7:0] SUB_MIX_B = 8'h95;
  localparam logic [7:0] SUB_IN_SEL = 8'h96;
  localparam logic [7:0] SUB_MONITOR = 8'h97;

  // ----------------------------------------------------------------
  // Reset values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_CHROMA_SAT = 16'h0757; // Cr 29, Cb 23
  localparam logic [7:0] RST_HUE_ROT = 8'h00;
  localparam logic [15:0] RST_LEVEL_GAIN = 16'h1B44; // Contrast 27, bright 68
  localparam logic [7:0] RST_MIX_A = 8'hF0; // Key gain -1
  localparam logic [7:0] RST_MIX_B = 8'hE0; // Mode 11, offset 32
  localparam logic [7:0] RST_IN_SEL = 8'h40; // Decimation bypassed
  localparam logic [15:0] MASK_CHROMA_SAT = 16'h0FFF;
  localparam logic [7:0] MASK_HUE_ROT = 8'h3F;
  localparam logic [15:0] MASK_LEVEL_GAIN = 16'h3FFF;
  localparam logic [7:0] MASK_MIX_A = 8'hF3;
  localparam logic [7:0] MASK_IN_SEL = 8'hE6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SAT_CB_LSB = 0;
  localparam int SAT_CR_LSB = 6;
  localparam int CONTRAST_LSB = 8;
  localparam int MIXA_DELAY_BIT = 0;
  localparam int MIXA_CURVE_BIT = 1;
  localparam int MIXA_GAIN_LSB = 4;
  localparam int MIXB_MODE_LSB = 6;
  localparam int SEL_RANGE_BIT = 1;
  localparam int SEL_PORT_BIT = 2;
  localparam int SEL_CLAMP_BIT = 5;
  localparam int SEL_BYPASS_BIT = 6;
  localparam int SEL_YCRCB_BIT = 7;

  // ----------------------------------------------------------------
  // Key arithmetic
  // ----------------------------------------------------------------
  localparam logic [6:0] KEY_FULL = 7'd64;
  localparam logic [6:0] KEY_CLAMP_BASE = 7'd31;

  // Serial port controller states
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_SUB, S_WR, S_RD} ser_state_t;

endpackage : cip_ctrl_pkg

// >>> rtl/component_input_mixer_control.sv
`timescale 1ns/1ps
// Overview of operation
// - Saturation holds blue and red chroma gains
// - Six-bit tint rotates component hue by tint/64 radians, up to half a radian
// - Signed brightness adds luma offset
// - Six-bit contrast scales component luma
// - Mixer bit zero picks path delay matching
// - Mixer bit one picks linear/nonlinear curve
// - Signed key gain scales key; middle bits zero
// - Offset correction subtracted from key
// - Mode: x0 component, 01 mix, 11 main
// - Range bit extends converter range 3 dB
// - Port bit selects input port one/two
// - Clamp bit fixes key at 31 minus offset
// - Bypass bit skips chroma decimation, set at reset
// - YCrCb/RGB select; bits four, three and zero held at zero
// - High flag sets on key, clears read-and-low
// - Fall flag latches falling key edge
// - Rise flag latches rising key edge
// - Live key level captured at read
// - Clip flag latches on input clip
module component_input_mixer_control #(
  parameter logic [6:0] DEV_ADDR = 7'h2B // Arbitrary bus address
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  // Serial control port (open drain data)
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  // Component and main video, system clock domain
  input wire logic [7:0] COMP_Y_I,
  input wire logic [7:0] COMP_CB_I,
  input wire logic [7:0] COMP_CR_I,
  input wire logic COMP_CLIP_I,
  input wire logic [7:0] MAIN_Y_I,
  input wire logic [7:0] MAIN_CB_I,
  input wire logic [7:0] MAIN_CR_I,
  // Blanking key pin
  input wire logic BLANKING_KEY_I,
  // Mixed video out
  output logic [7:0] MIX_Y_O,
  output logic [7:0] MIX_CB_O,
  output logic [7:0] MIX_CR_O,
  // Front-end controls
  output logic EXTENDED_RANGE_O,
  output logic INPUT_PORT_SELECT_O,
  output logic DECIMATION_BYPASS_O,
  output logic YCRCB_MODE_O,
  output logic PATH_DELAY_MODE_O
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_reg; // Bit 0 is the metastable stage
  logic [1:0] sda_sync_reg;
  logic [1:0] key_sync_reg;
  logic scl_prev_reg; // Delayed copies for edge detection
  logic sda_prev_reg;
  logic key_prev_reg;

  // Two flops per pin, edge detectors look only at the second
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_B_I)
    begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      key_sync_reg <= 2'b00;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      key_prev_reg <= 1'b0;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], SCL_I};
      sda_sync_reg <= {sda_sync_reg[0], SDA_I};
      key_sync_reg <= {key_sync_reg[0], BLANKING_KEY_I};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
      key_prev_reg <= key_sync_reg[1];
    end
  end

  wire scl = scl_sync_reg[1];
  wire sda = sda_sync_reg[1];
  wire key = key_sync_reg[1];
  wire scl_rise = scl & ~scl_prev_reg;
  wire scl_fall = ~scl & scl_prev_reg;
  wire bus_start = scl & scl_prev_reg & sda_prev_reg & ~sda;
  wire bus_stop = scl & scl_prev_reg & ~sda_prev_reg & sda;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] chroma_sat_reg;
  logic [7:0] hue_rot_reg;
  logic [15:0] level_gain_reg;
  logic [7:0] mix_a_reg;
  logic [7:0] mix_b_reg;
  logic [7:0] in_sel_reg;
  logic [4:0] monitor_reg; // Clip, live, rise, fall, high
  logic wr_stb; // One-cycle write commit
  logic [7:0] wr_sub;
  logic [15:0] wr_data;
  logic mon_read; // One-cycle monitor read strobe

  // Word registers take two bytes, high byte first
  function automatic logic is_word(input logic [7:0] s);
    is_word = (s == cip_ctrl_pkg::SUB_CHROMA_SAT) || (s == cip_ctrl_pkg::SUB_LEVEL_GAIN);
  endfunction : is_word

  // Control registers; reserved bits are dropped on write
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_B_I)
    begin
      chroma_sat_reg <= cip_ctrl_pkg::RST_CHROMA_SAT;
      hue_rot_reg <= cip_ctrl_pkg::RST_HUE_ROT;
      level_gain_reg <= cip_ctrl_pkg::RST_LEVEL_GAIN;
      mix_a_reg <= cip_ctrl_pkg::RST_MIX_A;
      mix_b_reg <= cip_ctrl_pkg::RST_MIX_B;
      in_sel_reg <= cip_ctrl_pkg::RST_IN_SEL;
    end
    else if (wr_stb)
    begin
      case (wr_sub)
        cip_ctrl_pkg::SUB_CHROMA_SAT:
          chroma_sat_reg <= wr_data & cip_ctrl_pkg::MASK_CHROMA_SAT;
        cip_ctrl_pkg::SUB_HUE_ROT:
          hue_rot_reg <= wr_data[7:0] & cip_ctrl_pkg::MASK_HUE_ROT;
        cip_ctrl_pkg::SUB_LEVEL_GAIN:
          level_gain_reg <= wr_data & cip_ctrl_pkg::MASK_LEVEL_GAIN;
        cip_ctrl_pkg::SUB_MIX_A: mix_a_reg <= wr_data[7:0] & cip_ctrl_pkg::MASK_MIX_A;
        cip_ctrl_pkg::SUB_MIX_B: mix_b_reg <= wr_data[7:0];
        cip_ctrl_pkg::SUB_IN_SEL: in_sel_reg <= wr_data[7:0] & cip_ctrl_pkg::MASK_IN_SEL;
        default: ; // Unmapped or read-only: ignored
      endcase
    end
  end

  // Monitor flags: an event in the read cycle wins over the clear
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_B_I)
      monitor_reg <= 5'h00;
    else
    begin
      monitor_reg[0] <= key | (monitor_reg[0] & ~(mon_read & ~key));
      monitor_reg[1] <= (~key & key_prev_reg) | (monitor_reg[1] & ~mon_read);
      monitor_reg[2] <= (key & ~key_prev_reg) | (monitor_reg[2] & ~mon_read);
      monitor_reg[3] <= mon_read ? key : monitor_reg[3];
      monitor_reg[4] <= COMP_CLIP_I | (monitor_reg[4] & ~mon_read);
    end
  end

  // Read view of a subaddress; live level is the current key
  function automatic logic [15:0] read_word(input logic [7:0] s, input logic [15:0] sat,
      input logic [7:0] hue, input logic [15:0] lvl, input logic [7:0] ma,
      input logic [7:0] mb, input logic [7:0] sel, input logic [4:0] mon, input logic k);
    case (s)
      cip_ctrl_pkg::SUB_CHROMA_SAT: read_word = sat;
      cip_ctrl_pkg::SUB_HUE_ROT: read_word = {8'h00, hue};
      cip_ctrl_pkg::SUB_LEVEL_GAIN: read_word = lvl;
      cip_ctrl_pkg::SUB_MIX_A: read_word = {8'h00, ma};
      cip_ctrl_pkg::SUB_MIX_B: read_word = {8'h00, mb};
      cip_ctrl_pkg::SUB_IN_SEL: read_word = {8'h00, sel};
      cip_ctrl_pkg::SUB_MONITOR: read_word = {11'h000, mon[4], k, mon[2:0]};
      default: read_word = 16'h0000;
    endcase
  endfunction : read_word

  // ----------------------------------------------------------------
  // Serial port: address, subaddress, data bytes
  // ----------------------------------------------------------------
  cip_ctrl_pkg::ser_state_t state_reg;
  logic [3:0] bit_cnt_reg; // Bits seen in current byte
  logic [7:0] shift_reg; // Incoming byte
  logic [7:0] tx_reg; // Outgoing bits, MSB first
  logic ack_phase_reg; // Ninth clock of a byte
  logic byte_idx_reg; // 0 = high byte of a word
  logic [7:0] sub_reg;
  logic [7:0] hold_hi_reg;
  logic [7:0] rd_byte;
  logic [15:0] rd_word;

  always_comb
  begin
    rd_word = read_word(sub_reg, chroma_sat_reg, hue_rot_reg, level_gain_reg, mix_a_reg,
        mix_b_reg, in_sel_reg, monitor_reg, key);
    rd_byte = (is_word(sub_reg) && !byte_idx_reg) ? rd_word[15:8] : rd_word[7:0];
  end

  assign mon_read = scl_fall && ack_phase_reg && state_reg == cip_ctrl_pkg::S_RD
    && sub_reg == cip_ctrl_pkg::SUB_MONITOR;

  // Byte framing, acknowledge and data shifting
  always_ff @(posedge CLK_SYS_I)
  begin
    wr_stb <= 1'b0;
    if (!RST_B_I)
    begin
      state_reg <= cip_ctrl_pkg::S_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ack_phase_reg <= 1'b0;
      byte_idx_reg <= 1'b0;
      sub_reg <= 8'h00;
      hold_hi_reg <= 8'h00;
      wr_sub <= 8'h00;
      wr_data <= 16'h0000;
      SDA_OE_O <= 1'b0;
    end
    else if (bus_start)
    begin
      // Start or repeated start opens a new address byte
      state_reg <= cip_ctrl_pkg::S_ADDR;
      bit_cnt_reg <= 4'h0;
      ack_phase_reg <= 1'b0;
      SDA_OE_O <= 1'b0;
    end
    else if (bus_stop)
    begin
      state_reg <= cip_ctrl_pkg::S_IDLE;
      SDA_OE_O <= 1'b0;
    end
    else if (scl_rise && state_reg != cip_ctrl_pkg::S_IDLE)
    begin
      if (!ack_phase_reg)
      begin
        shift_reg <= {shift_reg[6:0], sda};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      else if (state_reg == cip_ctrl_pkg::S_RD && sda)
        state_reg <= cip_ctrl_pkg::S_IDLE; // Master declined more data
    end
    else if (scl_fall && state_reg != cip_ctrl_pkg::S_IDLE)
    begin
      if (ack_phase_reg)
      begin
        // End of ninth clock; a read drives its next byte at once
        ack_phase_reg <= 1'b0;
        SDA_OE_O <= 1'b0;
        if (state_reg == cip_ctrl_pkg::S_RD)
        begin
          SDA_OE_O <= ~rd_byte[7];
          tx_reg <= {rd_byte[6:0], 1'b0};
          byte_idx_reg <= is_word(sub_reg) ? ~byte_idx_reg : 1'b0;
        end
      end
      else if (bit_cnt_reg == 4'h8)
      begin
        bit_cnt_reg <= 4'h0;
        ack_phase_reg <= 1'b1;
        SDA_OE_O <= 1'b1; // Acknowledge by default
        case (state_reg)
          cip_ctrl_pkg::S_ADDR:
          begin
            byte_idx_reg <= 1'b0;
            if (shift_reg[7:1] != DEV_ADDR)
            begin
              // Not ours: stay off the bus until the next start
              state_reg <= cip_ctrl_pkg::S_IDLE;
              ack_phase_reg <= 1'b0;
              SDA_OE_O <= 1'b0;
            end
            else if (shift_reg[0])
              state_reg <= cip_ctrl_pkg::S_RD;
            else
              state_reg <= cip_ctrl_pkg::S_SUB;
          end
          cip_ctrl_pkg::S_SUB:
          begin
            sub_reg <= shift_reg;
            state_reg <= cip_ctrl_pkg::S_WR;
          end
          cip_ctrl_pkg::S_WR:
          begin
            if (is_word(sub_reg) && !byte_idx_reg)
            begin
              hold_hi_reg <= shift_reg;
              byte_idx_reg <= 1'b1;
            end
            else
            begin
              wr_stb <= 1'b1;
              wr_sub <= sub_reg;
              wr_data <= {is_word(sub_reg) ? hold_hi_reg : 8'h00, shift_reg};
              byte_idx_reg <= 1'b0;
            end
          end
          cip_ctrl_pkg::S_RD:
            SDA_OE_O <= 1'b0; // Master owns the ninth bit
          default:
            SDA_OE_O <= 1'b0;
        endcase
      end
      else if (state_reg == cip_ctrl_pkg::S_RD)
      begin
        SDA_OE_O <= ~tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // Open drain: only ever pull low
  assign SDA_O = 1'b0;

  // ----------------------------------------------------------------
  // Component processing and key mixer
  // ----------------------------------------------------------------
  logic signed [17:0] y_p, cb_p, cr_p, cb_t, cr_t;
  logic signed [9:0] cb_c, cr_c, tint;
  logic [7:0] y_pix, cb_pix, cr_pix, cb_out, cr_out;
  logic [7:0] cb_prev_reg, cr_prev_reg; // Previous chroma for decimation
  logic [7:0] main_y_reg, main_cb_reg, main_cr_reg; // Main path match stage
  logic signed [9:0] key_g, key_o;
  logic [6:0] key_v, key_mix;
  logic [13:0] key_sq;

  localparam logic [6:0] KEY64 = cip_ctrl_pkg::KEY_FULL;
  // Saturate to one video byte
  function automatic logic [7:0] clip8(input logic signed [17:0] v);
    clip8 = (v < 18'sd0) ? 8'h00 : (v > 18'sd255) ? 8'hFF : v[7:0];
  endfunction : clip8

  // Weighted blend, k in 0..64 selects main
  function automatic logic [7:0] blend(input logic [7:0] c, input logic [7:0] m,
      input logic [6:0] k);
    logic [14:0] acc;
    acc = 15'(c) * 15'(KEY64 - k) + 15'(m) * 15'(k);
    blend = acc[13:6];
  endfunction : blend

  always_comb
  begin
    // Luma: contrast around black, then brightness offset
    y_p = ((($signed({10'h000, COMP_Y_I}) - 18'sd16)
        * $signed({12'h000, level_gain_reg[cip_ctrl_pkg::CONTRAST_LSB +: 6]})) >>> 5)
        + 18'sd16 + 18'($signed(level_gain_reg[7:0]));
    y_pix = clip8(y_p);
    // Chroma: small-angle hue rotation, then per-component gain
    cb_c = $signed({2'b00, COMP_CB_I}) - 10'sd128;
    cr_c = $signed({2'b00, COMP_CR_I}) - 10'sd128;
    tint = 10'($signed(hue_rot_reg[5:0]));
    cb_t = 18'(cb_c) - ((18'(cr_c) * 18'(tint)) >>> 6);
    cr_t = 18'(cr_c) + ((18'(cb_c) * 18'(tint)) >>> 6);
    cb_p = ((cb_t * $signed({12'h000, chroma_sat_reg[cip_ctrl_pkg::SAT_CB_LSB +: 6]})) >>> 5)
        + 18'sd128;
    cr_p = ((cr_t * $signed({12'h000, chroma_sat_reg[cip_ctrl_pkg::SAT_CR_LSB +: 6]})) >>> 5)
        + 18'sd128;
    cb_pix = clip8(cb_p);
    cr_pix = clip8(cr_p);
    // Two-tap average unless the decimation filter is bypassed
    cb_out = in_sel_reg[cip_ctrl_pkg::SEL_BYPASS_BIT] ? cb_pix
        : 8'((9'(cb_pix) + 9'(cb_prev_reg)) >> 1);
    cr_out = in_sel_reg[cip_ctrl_pkg::SEL_BYPASS_BIT] ? cr_pix
        : 8'((9'(cr_pix) + 9'(cr_prev_reg)) >> 1);
    // Key: gain scales the full key as (8 + gain) / 8
    key_g = key ? 10'sd8 * (10'sd8 + 10'($signed(mix_a_reg[cip_ctrl_pkg::MIXA_GAIN_LSB +: 4])))
        : 10'sd0;
    if (in_sel_reg[cip_ctrl_pkg::SEL_CLAMP_BIT])
      key_o = $signed({3'b000, cip_ctrl_pkg::KEY_CLAMP_BASE})
        - $signed({4'h0, mix_b_reg[5:0]});
    else
      key_o = key_g - $signed({4'h0, mix_b_reg[5:0]});
    key_v = (key_o < 10'sd0) ? 7'd0 : (key_o > 10'sd64) ? KEY64 : key_o[6:0];
    key_sq = 14'(key_v) * 14'(key_v);
    key_mix = mix_a_reg[cip_ctrl_pkg::MIXA_CURVE_BIT] ? key_sq[12:6] : key_v;
    case (mix_b_reg[cip_ctrl_pkg::MIXB_MODE_LSB +: 2])
      2'b01: ; // Key controls the blend
      2'b11: key_mix = KEY64;
      default: key_mix = 7'd0;
    endcase
  end

  // Output stage; normal delay mode holds main video one cycle
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_B_I)
    begin
      cb_prev_reg <= 8'h80;
      cr_prev_reg <= 8'h80;
      main_y_reg <= 8'h00;
      main_cb_reg <= 8'h80;
      main_cr_reg <= 8'h80;
      MIX_Y_O <= 8'h00;
      MIX_CB_O <= 8'h80;
      MIX_CR_O <= 8'h80;
    end
    else
    begin
      cb_prev_reg <= cb_pix;
      cr_prev_reg <= cr_pix;
      main_y_reg <= MAIN_Y_I;
      main_cb_reg <= MAIN_CB_I;
      main_cr_reg <= MAIN_CR_I;
      if (mix_a_reg[cip_ctrl_pkg::MIXA_DELAY_BIT])
      begin
        MIX_Y_O <= blend(y_pix, MAIN_Y_I, key_mix);
        MIX_CB_O <= blend(cb_out, MAIN_CB_I, key_mix);
        MIX_CR_O <= blend(cr_out, MAIN_CR_I, key_mix);
      end
      else
      begin
        MIX_Y_O <= blend(y_pix, main_y_reg, key_mix);
        MIX_CB_O <= blend(cb_out, main_cb_reg, key_mix);
        MIX_CR_O <= blend(cr_out, main_cr_reg, key_mix);
      end
    end
  end

  // ----------------------------------------------------------------
  // Front-end control outputs
  // ----------------------------------------------------------------
  assign EXTENDED_RANGE_O = in_sel_reg[cip_ctrl_pkg::SEL_RANGE_BIT];
  assign INPUT_PORT_SELECT_O = in_sel_reg[cip_ctrl_pkg::SEL_PORT_BIT];
  assign DECIMATION_BYPASS_O = in_sel_reg[cip_ctrl_pkg::SEL_BYPASS_BIT];
  assign YCRCB_MODE_O = in_sel_reg[cip_ctrl_pkg::SEL_YCRCB_BIT];
  assign PATH_DELAY_MODE_O = mix_a_reg[cip_ctrl_pkg::MIXA_DELAY_BIT];

endmodule : component_input_mixer_control

// >>> verif/cip_ctrl_assertions.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker for the component mixer control
// ------------------------------------------------------------
module cip_ctrl_assertions (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  // Serial port
  input wire logic SCL_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  // Mixed video and front-end controls
  input wire logic [7:0] MIX_Y_O,
  input wire logic [7:0] MIX_CB_O,
  input wire logic [7:0] MIX_CR_O,
  input wire logic EXTENDED_RANGE_O,
  input wire logic INPUT_PORT_SELECT_O,
  input wire logic DECIMATION_BYPASS_O,
  input wire logic YCRCB_MODE_O,
  input wire logic PATH_DELAY_MODE_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_B_I);
  // Controls gathered so one check covers every pin
  logic [4:0] ctrl;
  // Cycles the data line has been pulled in a row
  int oe_run;
  assign ctrl = {EXTENDED_RANGE_O, INPUT_PORT_SELECT_O, DECIMATION_BYPASS_O, YCRCB_MODE_O,
    PATH_DELAY_MODE_O};
  // Run length of the data pull
  always_ff @(posedge CLK_SYS_I)
  begin
    oe_run <= (!RST_B_I || !SDA_OE_O) ? 0 : oe_run + 1;
  end
  sequence s_release;
    $rose(RST_B_I);
  endsequence
  sequence s_oe_move;
    $changed(SDA_OE_O);
  endsequence
  a_reset_bypass: assert property (s_release |-> DECIMATION_BYPASS_O)
    else $error("decimation bypass not set after reset");
  a_reset_ctrls: assert property (s_release |-> ctrl == 5'h04)
    else $error("control pins differ from reset values");
  a_reset_mix: assert property (s_release |-> MIX_Y_O == 8'h00 && MIX_CB_O == 8'h80)
    else $error("mixed video not at reset level");
  a_oe_reset: assert property (s_release |-> !SDA_OE_O)
    else $error("data line pulled right after reset");
  a_sda_zero: assert property (SDA_O == 1'b0)
    else $error("data pin driven high");
  a_oe_scl_low: assert property (s_oe_move |-> !SCL_I && !$past(SCL_I))
    else $error("data line moved while bus clock high");
  a_ctrl_scl_low: assert property ($changed(ctrl) |-> !SCL_I)
    else $error("control pins changed outside a commit");
  a_oe_bounded: assert property (oe_run < 300)
    else $error("data line held low too long");
endmodule : cip_ctrl_assertions

bind component_input_mixer_control cip_ctrl_assertions chk_u (.CLK_SYS_I(CLK_SYS_I),
  .RST_B_I(RST_B_I), .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .MIX_Y_O(MIX_Y_O),
  .MIX_CB_O(MIX_CB_O), .MIX_CR_O(MIX_CR_O), .EXTENDED_RANGE_O(EXTENDED_RANGE_O),
  .INPUT_PORT_SELECT_O(INPUT_PORT_SELECT_O), .DECIMATION_BYPASS_O(DECIMATION_BYPASS_O),
  .YCRCB_MODE_O(YCRCB_MODE_O), .PATH_DELAY_MODE_O(PATH_DELAY_MODE_O));

// >>> verif/cip_bus_master.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Serial bus controller model on the far side
// ------------------------------------------------------------
module cip_bus_master (
  // Bench clock, paces the bus phases
  input wire logic clk_i,
  // Resolved data line, pulled up when nobody pulls
  input wire logic sda_i,
  // Bus clock and data pull enable
  output logic scl_o,
  output logic sda_oe_o
);
  // Twice the slave's minimum phase, leaving room for its sync delay
  localparam int HALF = 8;
  // Idle bus: clock high, data released
  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // Pins move 1 ns after an edge, never on it
  task automatic pace();
    repeat (HALF) @(posedge clk_i);
    #1;
  endtask : pace
  // Data moves only while the clock is low
  task automatic clock_bit(input logic b, output logic got);
    sda_oe_o = ~b;
    pace();
    scl_o = 1'b1;
    pace();
    got = sda_i;
    scl_o = 1'b0;
    pace();
  endtask : clock_bit
  // Also serves as repeated start
  task automatic start_cond();
    sda_oe_o = 1'b0;
    pace();
    scl_o = 1'b1;
    pace();
    sda_oe_o = 1'b1;
    pace();
    scl_o = 1'b0;
    pace();
  endtask : start_cond
  task automatic stop_cond();
    sda_oe_o = 1'b1;
    pace();
    scl_o = 1'b1;
    pace();
    sda_oe_o = 1'b0;
    pace();
  endtask : stop_cond
  // Eight bits msb first, then the acknowledge slot; a 1 releases the line
  task automatic xbyte(input logic [7:0] b, input logic ack_bit, output logic [7:0] got,
    output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      clock_bit(b[i], got[i]);
    end
    clock_bit(ack_bit, ack);
  endtask : xbyte
endmodule : cip_bus_master

// >>> verif/component_input_mixer_control_bench.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Self-checking bench for the component mixer control
// ------------------------------------------------------------
module component_input_mixer_control_bench;
  // Bus address given to the instance, arbitrary
  localparam logic [6:0] DEV = 7'h2B;
  // Table row: optional write, then read back
  typedef struct {logic wr; logic two; logic [7:0] sub; logic [15:0] wd; logic [15:0] exp;} row_t;
  // Monitor step: key and clip levels, then the expected monitor byte
  typedef struct {logic key; logic clip; logic [7:0] exp;} mon_t;
  logic clk_sys, rst_b, scl, mst_oe, sda_oe, sda_o, sda_line, key, clip;
  logic [7:0] cy, ccb, ccr, my, mcb, mcr, oy, ocb, ocr, v;
  logic rng, port, byp, ycc, dly;
  logic [15:0] rd;
  int err_total, n_checks;
  row_t rows [15];
  mon_t steps [5];
  // Open-drain data line with a pull-up
  assign sda_line = !(mst_oe || (sda_oe && !sda_o));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  component_input_mixer_control #(.DEV_ADDR(DEV)) dut_u (.CLK_SYS_I(clk_sys), .RST_B_I(rst_b),
    .SCL_I(scl), .SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .COMP_Y_I(cy),
    .COMP_CB_I(ccb), .COMP_CR_I(ccr), .COMP_CLIP_I(clip), .MAIN_Y_I(my), .MAIN_CB_I(mcb),
    .MAIN_CR_I(mcr), .BLANKING_KEY_I(key), .MIX_Y_O(oy), .MIX_CB_O(ocb), .MIX_CR_O(ocr),
    .EXTENDED_RANGE_O(rng), .INPUT_PORT_SELECT_O(port), .DECIMATION_BYPASS_O(byp),
    .YCRCB_MODE_O(ycc), .PATH_DELAY_MODE_O(dly));
  cip_bus_master mst_u (.clk_i(clk_sys), .sda_i(sda_line), .scl_o(scl), .sda_oe_o(mst_oe));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cycles
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // Start, address with write, subaddress; both must be acknowledged
  task automatic head(input logic [7:0] sub);
    logic ack;
    logic [7:0] nul;
    mst_u.start_cond();
    mst_u.xbyte({DEV, 1'b0}, 1'b1, nul, ack);
    check(24'(ack), 24'h00_0000);
    mst_u.xbyte(sub, 1'b1, nul, ack);
    check(24'(ack), 24'h00_0000);
  endtask : head
  // Wide registers go high byte first; the low byte commits
  task automatic wr_reg(input logic [7:0] sub, input logic two, input logic [15:0] d);
    logic ack;
    logic [7:0] nul;
    head(sub);
    if (two)
    begin
      mst_u.xbyte(d[15:8], 1'b1, nul, ack);
    end
    mst_u.xbyte(d[7:0], 1'b1, nul, ack);
    mst_u.stop_cond();
  endtask : wr_reg
  // Last byte is refused by the controller to end the read
  task automatic rd_reg(input logic [7:0] sub, input logic two, output logic [15:0] d);
    logic ack;
    head(sub);
    mst_u.start_cond();
    mst_u.xbyte({DEV, 1'b1}, 1'b1, d[7:0], ack);
    check(24'(ack), 24'h00_0000);
    d = 16'h0000;
    if (two)
    begin
      mst_u.xbyte(8'hFF, 1'b0, d[15:8], ack);
    end
    mst_u.xbyte(8'hFF, 1'b1, d[7:0], ack);
    mst_u.stop_cond();
  endtask : rd_reg
  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    err_total++;
    tally_and_finish();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    rows = '{'{1'b0, 1'b1, 8'h90, 16'h0000, 16'h0757}, '{1'b0, 1'b0, 8'h91, 16'h0000, 16'h0000},
      '{1'b0, 1'b1, 8'h92, 16'h0000, 16'h1B44}, '{1'b0, 1'b0, 8'h94, 16'h0000, 16'h00F0},
      '{1'b0, 1'b0, 8'h95, 16'h0000, 16'h00E0}, '{1'b0, 1'b0, 8'h96, 16'h0000, 16'h0040},
      '{1'b0, 1'b0, 8'h97, 16'h0000, 16'h0000}, '{1'b1, 1'b1, 8'h90, 16'hFFFF, 16'h0FFF},
      '{1'b1, 1'b0, 8'h91, 16'h00FF, 16'h003F}, '{1'b1, 1'b1, 8'h92, 16'hFFFF, 16'h3FFF},
      '{1'b1, 1'b0, 8'h94, 16'h00FF, 16'h00F3}, '{1'b1, 1'b0, 8'h95, 16'h007F, 16'h007F},
      '{1'b1, 1'b0, 8'h96, 16'h00FF, 16'h00E6}, '{1'b1, 1'b0, 8'h93, 16'h0055, 16'h0000},
      '{1'b1, 1'b0, 8'h97, 16'h00FF, 16'h0000}};
    // Rise, hold high, fall, quiet, clip pulse
    steps = '{'{1'b1, 1'b0, 8'h0D}, '{1'b1, 1'b0, 8'h09}, '{1'b0, 1'b0, 8'h03},
      '{1'b0, 1'b0, 8'h00}, '{1'b0, 1'b1, 8'h10}};
    {key, clip, rst_b} = 3'b000;
    {cy, ccb, ccr, my, mcb, mcr} = {8'h50, 8'h60, 8'hA0, 8'h30, 8'h90, 8'h70};
    err_total = 0;
    n_checks = 0;
    // Two edges in reset, all resets are synchronous
    cycles(2);
    rst_b = 1'b1;
    cycles(4);
    // Reset values, masks of reserved bits, unmapped and read-only places
    foreach (rows[i])
    begin
      if (rows[i].wr)
      begin
        wr_reg(rows[i].sub, rows[i].two, rows[i].wd);
      end
      rd_reg(rows[i].sub, rows[i].two, rd);
      check(24'(rd), 24'(rows[i].exp));
    end
    // Monitor flags, each read clearing what it reported except the high flag while the key is high
    foreach (steps[i])
    begin
      key = steps[i].key;
      clip = steps[i].clip;
      cycles(2);
      clip = 1'b0;
      cycles(6);
      rd_reg(8'h97, 1'b0, rd);
      check(24'(rd), 24'(steps[i].exp));
    end
    // Control pins follow their bits, both polarities
    for (int j = 0; j < 2; j++)
    begin
      v = j ? 8'h42 : 8'hA4;
      wr_reg(8'h96, 1'b0, {8'h00, v});
      wr_reg(8'h94, 1'b0, {15'h0000, v[1]});
      cycles(8);
      check(24'({ycc, byp, port, rng, dly}), 24'({v[7], v[6], v[2], v[1], v[1]}));
    end
    // Unity picture settings, YCrCb input, full key; each mode picks a source
    wr_reg(8'h92, 1'b1, 16'h2000);
    wr_reg(8'h90, 1'b1, 16'h0820);
    wr_reg(8'h91, 1'b0, 16'h0000);
    wr_reg(8'h96, 1'b0, 16'h0080);
    wr_reg(8'h94, 1'b0, 16'h0000);
    key = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(8'h95, 1'b0, {8'h00, 2'(m), 6'h00});
      cycles(10);
      check({oy, ocb, ocr}, m[0] ? {my, mcb, mcr} : {cy, ccb, ccr});
    end
    tally_and_finish();
  end
endmodule : component_input_mixer_control_bench
